// File: hw/dacp_pkg.sv
package dacp_pkg;

  // Clock rate and conversion timing.
  localparam int CLK_MHZ = 125;
  localparam int T_CONV_CH_NS = 750;
  localparam int T_ACQ_NS = 250;
  localparam logic [15:0] CONV_CH_CYC = 16'((T_CONV_CH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] ACQ_CYC = 16'((T_ACQ_NS * CLK_MHZ + 999) / 1000);

  // Result codes at the ends of the range.
  localparam logic [15:0] CODE_MAX = 16'hffff;
  localparam logic [15:0] CODE_MIN = 16'h0000;

  // Serial frame length and its bit pointer.
  localparam logic [5:0] SER_BITS = 6'h20;
  localparam logic [5:0] SER_IDX_RST = 6'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CONV_A = 4'h2,
    ST_CONV_B = 4'h4,
    ST_ACQ = 4'h8
  } dacp_state_t;

  // Pins from the far side, all outside the clock domain.
  typedef struct packed {
    logic convert_request_n;
    logic cs_n;
    logic rd_n;
    logic serial_clk;
    logic reset_pin;
    logic power_down;
    logic impulse_mode;
    logic interface_style_select;
    logic byte_order_swap;
    logic chan_a_select;
    logic input_pair_select;
  } dacp_pins_t;

  localparam dacp_pins_t PINS_RST = '{
    convert_request_n: 1'b1, cs_n: 1'b1, rd_n: 1'b1, serial_clk: 1'b0,
    reset_pin: 1'b0, power_down: 1'b0, impulse_mode: 1'b0,
    interface_style_select: 1'b0, byte_order_swap: 1'b0,
    chan_a_select: 1'b1, input_pair_select: 1'b0};

endpackage

// File: hw/dacp_top.sv
// How it works
// - A convert request fall starts a conversion that then ignores requests and power-down.
// - Convert requests act regardless of chip-select and read-enable.
// - Impulse mode with request held low self-times acquisition and restarts conversion.
// - Request kept low in impulse mode keeps conversions running back to back.
// - Normal mode never restarts by itself; each conversion needs a request.
// - Impulse mode powers the core down after conversion, interface stays alive.
// - Outputs are high impedance whenever chip-select or read-enable is high.
// - Reset input high abandons conversion and floats the data bus.
// - Style select low gives parallel bus, high gives serial output.
// - Chip-select and read-enable tied low drive the bus continuously.
// - Byte swap low puts low byte on D[7:0], high exchanges bytes.
// - Parallel mode: channel select high shows first channel, low the second.
// - First channel result is readable in parallel once its conversion ends.
// - Serial data updates only after the second channel finishes.
// - Serial mode shifts 32 bits out, MSB first, one per serial clock.
// - Channel select high sends first channel first, low sends second first.
// - Pair select low samples first pair, high second; followed in idle and acquisition, held during conversion.
// - The first channel is always converted before the second.
// - Results are straight binary, clamped to 0xFFFF and 0x0000.
// - Busy is high during conversion, low once both channels are done.
`timescale 1ns/10ps
`default_nettype none

module dacp_top
  import dacp_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Pins from the host.
  input wire dacp_pins_t pins_in,
  // Raw codes from the converter core, wider than the result.
  input wire logic signed [17:0] core_code_a,
  input wire logic signed [17:0] core_code_b,
  // Status and core control.
  output logic busy,
  output logic [1:0] conv_phase,
  output logic core_power_on,
  output logic mux_pair,
  // Data bus, serial output shares it.
  output logic [15:0] data_out,
  output logic data_oe,
  output logic serial_result_out,
  output logic serial_oe
);

  dacp_pins_t s1_ff, s2_ff, s3_ff, pf_ff, nxt_pf;
  logic cnv_prev_ff, sclk_prev_ff;
  dacp_state_t st_ff, nxt_st;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [15:0] par_a_ff, par_b_ff, ser_a_ff, ser_b_ff;
  logic [15:0] nxt_par_a, nxt_par_b, nxt_ser_a, nxt_ser_b;
  logic [5:0] ser_idx_ff, nxt_ser_idx;
  logic busy_ff, nxt_busy, pwr_ff, nxt_pwr, pair_ff, nxt_pair;
  logic [1:0] phase_ff, nxt_phase;
  logic [15:0] dout_ff, nxt_dout;
  logic doe_ff, nxt_doe, sout_ff, nxt_sout, soe_ff, nxt_soe;
  logic cnv_fall, sclk_rise, cnt_done, rd_en;
  logic [31:0] ser_word;
  logic [15:0] par_word;

  function automatic logic [15:0] clamp(input logic signed [17:0] code);
    if (code < 18'sh00000)
      clamp = CODE_MIN;
    else if (code > 18'sh0ffff)
      clamp = CODE_MAX;
    else
      clamp = code[15:0];
  endfunction

  // A bit changes only once the second and third stages agree.
  always_comb
  begin
    nxt_pf = dacp_pins_t'((s2_ff & s3_ff) | (pf_ff & (s2_ff | s3_ff)));
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      s1_ff <= PINS_RST;
      s2_ff <= PINS_RST;
      s3_ff <= PINS_RST;
      pf_ff <= PINS_RST;
      cnv_prev_ff <= 1'b1;
      sclk_prev_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= pins_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pf_ff <= nxt_pf;
      cnv_prev_ff <= pf_ff.convert_request_n;
      sclk_prev_ff <= pf_ff.serial_clk;
    end
  end

  // Chip-select and read-enable play no part in starting conversions.
  assign cnv_fall = cnv_prev_ff && !pf_ff.convert_request_n;
  assign sclk_rise = !sclk_prev_ff && pf_ff.serial_clk;
  assign cnt_done = (cnt_ff == 16'h0001);
  assign rd_en = !pf_ff.cs_n && !pf_ff.rd_n && !pf_ff.reset_pin;

  // Conversion sequencer.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_par_a = par_a_ff;
    nxt_par_b = par_b_ff;
    nxt_ser_a = ser_a_ff;
    nxt_ser_b = ser_b_ff;
    nxt_pair = pair_ff;
    case (st_ff)
      ST_IDLE:
      begin
        nxt_pair = pf_ff.input_pair_select;
        if (!pf_ff.power_down && cnv_fall)
        begin
          nxt_st = ST_CONV_A;
          nxt_cnt = CONV_CH_CYC;
        end
        else if (!pf_ff.power_down && pf_ff.impulse_mode && !pf_ff.convert_request_n)
        begin
          nxt_st = ST_ACQ;
          nxt_cnt = ACQ_CYC;
        end
      end
      ST_CONV_A:
      begin
        nxt_cnt = cnt_ff - 16'h0001;
        if (cnt_done)
        begin
          nxt_par_a = clamp(core_code_a);
          nxt_st = ST_CONV_B;
          nxt_cnt = CONV_CH_CYC;
        end
      end
      ST_CONV_B:
      begin
        nxt_cnt = cnt_ff - 16'h0001;
        if (cnt_done)
        begin
          nxt_par_b = clamp(core_code_b);
          nxt_ser_a = par_a_ff;
          nxt_ser_b = clamp(core_code_b);
          if (pf_ff.impulse_mode && !pf_ff.convert_request_n)
          begin
            nxt_st = ST_ACQ;
            nxt_cnt = ACQ_CYC;
          end
          else
            nxt_st = ST_IDLE;
        end
      end
      ST_ACQ:
      begin
        nxt_pair = pf_ff.input_pair_select;
        nxt_cnt = cnt_ff - 16'h0001;
        if (pf_ff.convert_request_n || pf_ff.power_down || !pf_ff.impulse_mode)
          nxt_st = ST_IDLE;
        else if (cnt_done)
        begin
          nxt_st = ST_CONV_A;
          nxt_cnt = CONV_CH_CYC;
        end
      end
      default:
        nxt_st = ST_IDLE;
    endcase
    // The reset pin abandons whatever is running.
    if (pf_ff.reset_pin)
    begin
      nxt_st = ST_IDLE;
      nxt_cnt = 16'h0000;
    end
    nxt_busy = (nxt_st == ST_CONV_A) || (nxt_st == ST_CONV_B);
    nxt_phase = {nxt_st == ST_CONV_B, nxt_st == ST_CONV_A};
    // In impulse mode the core sleeps outside conversion; logic keeps running.
    if (nxt_busy)
      nxt_pwr = 1'b1;
    else
      nxt_pwr = !pf_ff.impulse_mode && !pf_ff.power_down;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      st_ff <= ST_IDLE;
      cnt_ff <= 16'h0000;
      par_a_ff <= CODE_MIN;
      par_b_ff <= CODE_MIN;
      ser_a_ff <= CODE_MIN;
      ser_b_ff <= CODE_MIN;
      pair_ff <= 1'b0;
      busy_ff <= 1'b0;
      phase_ff <= 2'h0;
      pwr_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      par_a_ff <= nxt_par_a;
      par_b_ff <= nxt_par_b;
      ser_a_ff <= nxt_ser_a;
      ser_b_ff <= nxt_ser_b;
      pair_ff <= nxt_pair;
      busy_ff <= nxt_busy;
      phase_ff <= nxt_phase;
      pwr_ff <= nxt_pwr;
    end
  end

  // Readout. The serial pointer rewinds whenever the port is deselected.
  assign ser_word = pf_ff.chan_a_select ? {ser_a_ff, ser_b_ff} : {ser_b_ff, ser_a_ff};
  assign par_word = pf_ff.chan_a_select ? par_a_ff : par_b_ff;

  always_comb
  begin
    nxt_ser_idx = ser_idx_ff;
    if (!rd_en || !pf_ff.interface_style_select)
      nxt_ser_idx = SER_IDX_RST;
    else if (sclk_rise && ser_idx_ff != SER_BITS)
      nxt_ser_idx = ser_idx_ff + 6'h01;
    nxt_dout = 16'h0000;
    nxt_sout = 1'b0;
    if (ser_idx_ff != SER_BITS)
      nxt_sout = ser_word[5'(6'h1f - ser_idx_ff)];
    if (pf_ff.byte_order_swap)
      nxt_dout = {par_word[7:0], par_word[15:8]};
    else
      nxt_dout = par_word;
    nxt_doe = rd_en && !pf_ff.interface_style_select;
    nxt_soe = rd_en && pf_ff.interface_style_select;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      ser_idx_ff <= SER_IDX_RST;
      dout_ff <= 16'h0000;
      sout_ff <= 1'b0;
      doe_ff <= 1'b0;
      soe_ff <= 1'b0;
    end
    else
    begin
      ser_idx_ff <= nxt_ser_idx;
      dout_ff <= nxt_dout;
      sout_ff <= nxt_sout;
      doe_ff <= nxt_doe;
      soe_ff <= nxt_soe;
    end
  end

  assign busy = busy_ff;
  assign conv_phase = phase_ff;
  assign core_power_on = pwr_ff;
  assign mux_pair = pair_ff;
  assign data_out = dout_ff;
  assign data_oe = doe_ff;
  assign serial_result_out = sout_ff;
  assign serial_oe = soe_ff;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_hiz_deselect: assert property ((pf_ff.cs_n || pf_ff.rd_n) |=> !doe_ff && !soe_ff)
    else $error("bus driven while deselected");
  chk_reset_abort: assert property (pf_ff.reset_pin |=> st_ff == ST_IDLE && !busy_ff && !doe_ff)
    else $error("reset pin did not abort and float");
  chk_conv_start: assert property (st_ff == ST_IDLE && cnv_fall && !pf_ff.power_down
    && !pf_ff.reset_pin |=> st_ff == ST_CONV_A && busy_ff)
    else $error("convert request did not start conversion");
  chk_conv_hold: assert property (st_ff == ST_CONV_A && !cnt_done && !pf_ff.reset_pin
    |=> st_ff == ST_CONV_A)
    else $error("conversion disturbed before completion");
  chk_normal_stop: assert property (st_ff == ST_CONV_B && cnt_done && !pf_ff.impulse_mode
    && !pf_ff.reset_pin |=> st_ff == ST_IDLE && !busy_ff)
    else $error("normal mode restarted by itself");
  chk_auto_acq: assert property (st_ff == ST_CONV_B && cnt_done && pf_ff.impulse_mode
    && !pf_ff.convert_request_n && !pf_ff.reset_pin |=> st_ff == ST_ACQ && !pwr_ff)
    else $error("impulse mode did not enter acquisition");
  chk_a_before_b: assert property (st_ff == ST_CONV_A && cnt_done && !pf_ff.reset_pin
    |=> st_ff == ST_CONV_B && par_a_ff == clamp($past(core_code_a)))
    else $error("channel order or first result wrong");
  chk_byte_swap: assert property (rd_en && !pf_ff.interface_style_select
    && pf_ff.byte_order_swap |=> {dout_ff[7:0], dout_ff[15:8]} == $past(par_word))
    else $error("byte swap not applied");
  chk_busy_phase: assert property (busy_ff == (phase_ff != 2'h0))
    else $error("busy and phase disagree");

endmodule

`default_nettype wire

// File: verification/dacp_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module dacp_host_model
(
  // Clock.
  input wire logic sys_clk,
  // Serial link toward the host.
  output logic serial_clk,
  input wire logic serial_result_out,
  input wire logic serial_oe
);
  // The host clock stands low between frames and runs at 64 ns inside one.
  initial serial_clk = 1'b0;

  // Samples just before each rise, so a slow bit update still lands in time.
  task automatic read_frame(output logic [31:0] word);
    word = 32'h00000000;
    for (int i = 0; i < 32; i++)
    begin
      repeat (4) @(posedge sys_clk);
      word = {word[30:0], serial_oe ? serial_result_out : 1'bx};
      serial_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      serial_clk <= 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// File: verification/dacp_top_tb.sv
`timescale 1ns/10ps
`default_nettype none

module dacp_top_tb
  import dacp_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_b;
  dacp_pins_t pins;
  dacp_pins_t pins_w;
  logic sclk;
  logic signed [17:0] code_a;
  logic signed [17:0] code_b;
  logic busy, core_power_on, mux_pair, data_oe, ser_out, serial_oe;
  logic [1:0] conv_phase;
  logic [15:0] data_out;
  logic [31:0] w;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;

  always #4 sys_clk = ~sys_clk;

  always_comb
  begin
    pins_w = pins;
    pins_w.serial_clk = sclk;
  end

  dacp_top dacp_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .pins_in(pins_w),
    .core_code_a(code_a), .core_code_b(code_b), .busy(busy), .conv_phase(conv_phase),
    .core_power_on(core_power_on), .mux_pair(mux_pair), .data_out(data_out),
    .data_oe(data_oe), .serial_result_out(ser_out), .serial_oe(serial_oe));

  dacp_host_model dacp_host_model_i (.sys_clk(sys_clk), .serial_clk(sclk),
    .serial_result_out(ser_out),
    .serial_oe(serial_oe));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // A second request and power-down arrive mid-conversion; both must be ignored.
  // With keep_low the request stays low, so impulse mode restarts on its own.
  task automatic convert(input logic keep_low, input logic mid_on, output int len);
    @(posedge sys_clk);
    pins.convert_request_n <= 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    len = 0;
    while (busy === 1'b1 && len < 400)
    begin
      @(posedge sys_clk);
      pins.convert_request_n <= !(keep_low || len < 8 || (len >= 40 && len < 48));
      pins.power_down <= (len >= 50 && len < 60);
      @(negedge sys_clk);
      len++;
      if (len == 70) check(conv_phase, 32'h1);
      if (len == 130) check(conv_phase, 32'h2);
      if (mid_on && len == 130) check({data_oe, data_out}, 32'h00011234);
    end
  endtask

  task automatic par(input logic a, input logic sw, input logic [15:0] exp);
    @(posedge sys_clk);
    pins.chan_a_select <= a;
    pins.byte_order_swap <= sw;
    repeat (8) @(negedge sys_clk);
    check({data_oe, data_out}, {1'b1, exp});
  endtask

  task automatic t_parallel;
    @(posedge sys_clk);
    pins.cs_n <= 1'b0;
    pins.rd_n <= 1'b0;
    code_a <= 18'sh01234;
    code_b <= 18'sh1ffff;
    convert(1'b0, 1'b1, n);
    check(n, 2 * CONV_CH_CYC);
    repeat (300) @(negedge sys_clk);
    check(busy, 32'h0);
    par(1'b1, 1'b0, 16'h1234);
    par(1'b1, 1'b1, 16'h3412);
    par(1'b0, 1'b0, 16'hffff);
    @(posedge sys_clk);
    pins.rd_n <= 1'b1;
    repeat (8) @(negedge sys_clk);
    check(data_oe, 32'h0);
    @(posedge sys_clk);
    pins.input_pair_select <= 1'b1;
    repeat (8) @(negedge sys_clk);
    check(mux_pair, 32'h1);
    $display("parallel done");
  endtask

  task automatic t_serial;
    @(posedge sys_clk);
    pins.interface_style_select <= 1'b1;
    pins.cs_n <= 1'b1;
    code_a <= -18'sh00003;
    code_b <= 18'sh0abcd;
    convert(1'b0, 1'b0, n);
    @(posedge sys_clk);
    pins.cs_n <= 1'b0;
    pins.rd_n <= 1'b0;
    pins.chan_a_select <= 1'b1;
    repeat (10) @(posedge sys_clk);
    dacp_host_model_i.read_frame(w);
    check(w, 32'h0000abcd);
    check({data_oe, serial_oe}, 32'h1);
    @(posedge sys_clk);
    pins.cs_n <= 1'b1;
    pins.chan_a_select <= 1'b0;
    repeat (10) @(posedge sys_clk);
    pins.cs_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    dacp_host_model_i.read_frame(w);
    check(w, 32'habcd0000);
    @(posedge sys_clk);
    pins.interface_style_select <= 1'b0;
    $display("serial done");
  endtask

  task automatic t_impulse;
    @(posedge sys_clk);
    pins.impulse_mode <= 1'b1;
    convert(1'b1, 1'b0, n);
    n = 0;
    while (busy !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
      if (n == 16) check(core_power_on, 32'h0);
    end
    check(n >= ACQ_CYC && n <= ACQ_CYC + 2, 32'h1);
    @(posedge sys_clk);
    pins.convert_request_n <= 1'b1;
    repeat (500) @(negedge sys_clk);
    check(busy, 32'h0);
    @(posedge sys_clk);
    pins.impulse_mode <= 1'b0;
    $display("impulse done");
  endtask

  task automatic t_reset_pin;
    @(posedge sys_clk);
    pins.convert_request_n <= 1'b0;
    repeat (20) @(negedge sys_clk);
    check({busy, data_oe}, 32'h3);
    @(posedge sys_clk);
    pins.reset_pin <= 1'b1;
    pins.convert_request_n <= 1'b1;
    repeat (8) @(negedge sys_clk);
    check({busy, data_oe}, 32'h0);
    @(posedge sys_clk);
    pins.reset_pin <= 1'b0;
    $display("reset pin done");
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      summarize();
    end
  end

  initial
  begin
    pins = PINS_RST;
    code_a = 18'sh00000;
    code_b = 18'sh00000;
    rst_b = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge sys_clk);
    check({busy, data_oe, serial_oe}, 32'h0);
    t_parallel();
    t_serial();
    t_impulse();
    t_reset_pin();
    summarize();
  end
endmodule

`default_nettype wire
